//--- hdl/samd_pkg.sv
/*
  Shared constants for the system address map decoder: region bounds,
  target indices, flash sector layout and the password state encoding.
  Assumes a 24-bit byte address and 16-bit data words.
*/
package samd_pkg;

  // Address space shape
  localparam int ADDR_W = 24;
  localparam int SEG_LSB = 16;
  localparam int PAGE_LSB = 14;
  localparam int SEG_COUNT = 256;
  localparam logic [7:0] SYS_SEG = 8'h00;

  // Segment 0 areas
  localparam logic [23:0] SREG_BASE = 24'h00fe00;
  localparam logic [23:0] SREG_END = 24'h00ffff;
  localparam logic [23:0] DUAL_PORT_RAM_BASE = 24'h00f600;
  localparam logic [23:0] DUAL_PORT_RAM_END = 24'h00fdff;
  localparam logic [23:0] DUAL_PORT_RAM_BIT_BASE = 24'h00fd00;
  localparam logic [23:0] EREG_BASE = 24'h00f000;
  localparam logic [23:0] EREG_END = 24'h00f1ff;
  localparam logic [23:0] XREG_BASE = 24'h00e000;
  localparam logic [23:0] XREG_END = 24'h00efff;
  localparam logic [23:0] DATRAM_BASE = 24'h00c000;

  // Program side areas
  localparam logic [23:0] FLASH_BASE = 24'hc00000;
  localparam logic [23:0] PROGRAM_SRAM_BASE = 24'he00000;
  localparam logic [23:0] PROGRAM_SRAM_END = 24'he007ff;
  localparam logic [23:0] TRAP_BASE = 24'hf80000;
  localparam logic [23:0] FREG_BASE = 24'hfff000;

  // Defaults for variant dependent sizes
  localparam logic [23:0] FLASH_BYTES_DEF = 24'h020000;
  localparam logic [23:0] DATRAM_BYTES_DEF = 24'h001000;
  localparam logic [23:0] FREG_DEF_BYTES_DEF = 24'h000100;

  // Read value of undefined flash register locations
  localparam logic [15:0] TRAP_CODE = 16'h1e9b;

  // Flash sector layout
  localparam logic [16:0] SMALL_AREA_BYTES = 17'h08000;
  localparam logic [2:0] LARGE_SECT_FIRST = 3'h3;
  localparam int BLOCK_LSB = 7;
  localparam int BLOCK_W = 10;

  // Target select bit positions
  localparam int T_FLASH = 0;
  localparam int T_PROGRAM_SRAM = 1;
  localparam int T_DATRAM = 2;
  localparam int T_DUAL_PORT_RAM = 3;
  localparam int T_SREG = 4;
  localparam int T_EREG = 5;
  localparam int T_XREG = 6;
  localparam int T_FREG = 7;
  localparam int TGT_W = 8;

  // Password unlock sequencer
  typedef enum logic [2:0] {
    PW_LOCKED = 3'b001,
    PW_HALF = 3'b010,
    PW_OPEN = 3'b100
  } samd_pw_t;

  // Sector number of a flash byte offset
  function automatic logic [2:0] flashSector(input logic [16:0] off);
    if (off < SMALL_AREA_BYTES)
      flashSector = {1'b0, off[14:13]};
    else
      flashSector = 3'(off[16:15]) + LARGE_SECT_FIRST;
  endfunction : flashSector

endpackage : samd_pkg

//--- hdl/samd_map_decode.sv
/*
  Pure combinational map decoder: one address in, a one-hot target
  select plus segment, page and page offset out. Assumes the caller
  treats an all-zero select without fregUndef as a reserved hit.
*/
`timescale 1ns/1ps
module samd_map_decode
  import samd_pkg::*;
#(
  parameter logic [23:0] FLASH_BYTES = FLASH_BYTES_DEF,
  parameter logic [23:0] DATRAM_BYTES = DATRAM_BYTES_DEF,
  parameter logic [23:0] FREG_DEF_BYTES = FREG_DEF_BYTES_DEF
)
(
  // Address in
  input wire logic [23:0] addr,
  // Decode out
  output logic [TGT_W-1:0] target,
  output logic fregUndef,
  output logic [7:0] segment,
  output logic [1:0] page,
  output logic [13:0] pageOff
);

  assign segment = addr[23:SEG_LSB];
  assign page = addr[SEG_LSB-1:PAGE_LSB];
  assign pageOff = addr[PAGE_LSB-1:0];

  // Region decode; at most one bit set, absent memories fall through
  always_comb
  begin
    target = '0;
    fregUndef = 1'b0;
    if (addr >= FREG_BASE)
    begin
      if ((addr - FREG_BASE) < FREG_DEF_BYTES)
        target[T_FREG] = 1'b1;
      else
        fregUndef = 1'b1;
    end
    else if (addr >= PROGRAM_SRAM_BASE && addr <= PROGRAM_SRAM_END)
      target[T_PROGRAM_SRAM] = 1'b1;
    else if (addr >= FLASH_BASE && (addr - FLASH_BASE) < FLASH_BYTES)
      target[T_FLASH] = 1'b1;
    else if (addr[23:SEG_LSB] == SYS_SEG)
    begin
      if (addr >= SREG_BASE)
        target[T_SREG] = 1'b1;
      else if (addr >= DUAL_PORT_RAM_BASE && addr <= DUAL_PORT_RAM_END)
        target[T_DUAL_PORT_RAM] = 1'b1;
      else if (addr >= EREG_BASE && addr <= EREG_END)
        target[T_EREG] = 1'b1;
      else if (addr >= XREG_BASE && addr <= XREG_END)
        target[T_XREG] = 1'b1;
      else if (addr >= DATRAM_BASE && (addr - DATRAM_BASE) < DATRAM_BYTES)
        target[T_DATRAM] = 1'b1;
    end
  end

endmodule : samd_map_decode

//--- hdl/samd_lane_gen.sv
/*
  Byte lane and bit mask generator for one 16-bit data access.
  Assumes word accesses ignore address bit 0 and bit accesses are word
  wide with a single-bit mask.
*/
`timescale 1ns/1ps
module samd_lane_gen
(
  // Access shape
  input wire logic isWord,
  input wire logic addr0,
  input wire logic isBit,
  input wire logic [3:0] bitIdx,
  // Data
  input wire logic [15:0] wdata,
  input wire logic [15:0] rword,
  // Lanes out
  output logic [1:0] be,
  output logic [15:0] bitMask,
  output logic [15:0] laneWdata,
  output logic [15:0] laneRdata
);

  always_comb
  begin
    if (isBit)
    begin
      be = 2'h3;
      bitMask = 16'h0001 << bitIdx;
      laneWdata = {16{wdata[0]}};
      laneRdata = {15'h0000, rword[bitIdx]};
    end
    else if (isWord)
    begin
      be = 2'h3;
      bitMask = 16'hffff;
      laneWdata = wdata;
      laneRdata = rword;
    end
    else
    begin
      be = addr0 ? 2'h2 : 2'h1;
      bitMask = addr0 ? 16'hff00 : 16'h00ff;
      laneWdata = {wdata[7:0], wdata[7:0]};
      laneRdata = {8'h00, addr0 ? rword[15:8] : rword[7:0]};
    end
  end

endmodule : samd_lane_gen

//--- hdl/samd_router.sv
/*
  Address map decoder and memory routing: fetch port via the program
  side, data port via the data side, plus flash protection and the
  programming gate. Assumes memories answer combinationally in the
  cycle their select is high; answers are registered here.
*/
//
// Behaviour
// - Linear space of 256 segments of 64 Kbytes, top byte selects.
// - Each segment has four 16-Kbyte pages, two bits above offset.
// - Byte and word access everywhere; lanes from size and addr bit 0.
// - Data memories and register areas live in segment 0, except the flash registers at FF'F000.
// - Register windows at 00'FE00-00'FFFF and 00'F000-00'F1FF.
// - Dual-port RAM answers at 00'F600 through 00'FDFF.
// - Top 256 bytes of dual-port RAM allow single-bit access.
// - Register-mode dual-port RAM locations are bit accessible anywhere.
// - Register bank: 16 words, lower eight also as byte halves.
// - Undefined flash register reads return trap code 1E9B.
// - Program SRAM at E0'0000-E0'07FF, only via program unit.
// - Data SRAM at 00'C000-00'CFFF, only via data unit.
// - Flash of 32, 64 or 128 Kbytes from C0'0000.
// - Flash: four 8-Kbyte sectors then up to three 32-Kbyte.
// - Sectors erased or programmed singly, programming in 128-byte blocks.
// - Small sector write protection works per pair of sectors.
// - Flash read protection lifted by a correct password sequence.
// - Flash delivers 64 bits in one cycle.
// - All fetches go through the program unit.
// - All data transfers go through the data unit.
// - Program-data link carries one direction per access, read or write.
`timescale 1ns/1ps
module samd_router
  import samd_pkg::*;
#(
  parameter logic [23:0] FLASH_BYTES = FLASH_BYTES_DEF,
  parameter logic [23:0] DATRAM_BYTES = DATRAM_BYTES_DEF,
  parameter logic [23:0] FREG_DEF_BYTES = FREG_DEF_BYTES_DEF,
  parameter logic [15:0] PWD_KEY0 = 16'ha5c3,
  parameter logic [15:0] PWD_KEY1 = 16'h3c5a
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fetch port
  input wire logic fetchReq,
  input wire logic [23:0] fetchAddr,
  output logic fetchAck,
  output logic [63:0] fetchData,
  output logic fetchErr,
  // Data port
  input wire logic dataReq,
  input wire logic [23:0] dataAddr,
  input wire logic dataWrite,
  input wire logic dataWord,
  input wire logic dataBit,
  input wire logic [3:0] bitIdx,
  input wire logic dataGpr,
  input wire logic [3:0] gprIdx,
  input wire logic [15:0] cpBase,
  input wire logic [15:0] dataWdata,
  output logic dataReady,
  output logic dataAck,
  output logic [15:0] dataRdata,
  output logic dataErr,
  output logic [7:0] dataSeg,
  output logic [1:0] dataPage,
  output logic [13:0] dataPageOff,
  // Flash array
  output logic flashSel,
  output logic [16:0] flashAddr,
  input wire logic [63:0] flashRdata,
  // Program sram
  output logic psramSel,
  output logic [10:0] psramAddr,
  output logic psramWe,
  output logic [7:0] psramBe,
  output logic [63:0] psramWdata,
  input wire logic [63:0] psramRdata,
  // Data side targets
  output logic [TGT_W-1:0] dmemSel,
  output logic [23:0] dmemAddr,
  output logic dmemWe,
  output logic [1:0] dmemBe,
  output logic [15:0] dmemBitMask,
  output logic [15:0] dmemWdata,
  input wire logic [15:0] dmemRdata,
  // Protection controls
  input wire logic [1:0] wrProtPair,
  input wire logic [2:0] wrProtLarge,
  input wire logic readProtEn,
  input wire logic pwdStrobe,
  input wire logic [15:0] pwdWord,
  input wire logic relock,
  output logic flashUnlocked,
  // Programming gate
  input wire logic progReq,
  input wire logic progErase,
  input wire logic [23:0] progAddr,
  output logic progGrant,
  output logic progDenied,
  output logic progEraseOut,
  output logic [2:0] progSector,
  output logic [BLOCK_W-1:0] progBlock
);

  logic [TGT_W-1:0] fTgt;
  logic [TGT_W-1:0] dTgt;
  logic [TGT_W-1:0] pTgt;
  logic dFregUndef;
  logic [7:0] dSeg;
  logic [1:0] dPage;
  logic [13:0] dOff;
  logic [23:0] dEff;
  logic [23:0] fFlashOff;
  logic [23:0] dFlashOff;
  logic [23:0] pFlashOff;
  logic dProg;
  logic bitOk;
  logic readLock;
  logic dErrNow;
  logic dataTake;
  logic progFromData;
  logic [15:0] progWord;
  logic [63:0] progWide;
  logic [15:0] rword;
  logic [1:0] laneBe;
  logic [15:0] laneMask;
  logic [15:0] laneWdata;
  logic [15:0] laneRdata;
  logic [2:0] pSect;
  logic pProt;
  samd_pw_t pwState;
  samd_pw_t next_pwState;
  logic next_fetchAck;
  logic [63:0] next_fetchData;
  logic next_fetchErr;
  logic next_dataAck;
  logic [15:0] next_dataRdata;
  logic next_dataErr;
  logic [7:0] next_dataSeg;
  logic [1:0] next_dataPage;
  logic [13:0] next_dataPageOff;
  logic next_progGrant;
  logic next_progDenied;
  logic next_progEraseOut;
  logic [2:0] next_progSector;
  logic [BLOCK_W-1:0] next_progBlock;

  // register bank address from context base
  always_comb
  begin
    if (!dataGpr)
      dEff = dataAddr;
    else if (dataWord)
      dEff = {SYS_SEG, cpBase + {11'h000, gprIdx, 1'b0}};
    else
      dEff = {SYS_SEG, cpBase + {12'h000, gprIdx}};
  end

  // Three decoders, one per requester
  samd_map_decode #(.FLASH_BYTES(FLASH_BYTES), .DATRAM_BYTES(DATRAM_BYTES),
    .FREG_DEF_BYTES(FREG_DEF_BYTES)) u_fetch_dec (
    .addr(fetchAddr), .target(fTgt), .fregUndef(), .segment(), .page(), .pageOff());
  samd_map_decode #(.FLASH_BYTES(FLASH_BYTES), .DATRAM_BYTES(DATRAM_BYTES),
    .FREG_DEF_BYTES(FREG_DEF_BYTES)) u_data_dec (
    .addr(dEff), .target(dTgt), .fregUndef(dFregUndef), .segment(dSeg), .page(dPage),
    .pageOff(dOff));
  samd_map_decode #(.FLASH_BYTES(FLASH_BYTES), .DATRAM_BYTES(DATRAM_BYTES),
    .FREG_DEF_BYTES(FREG_DEF_BYTES)) u_prog_dec (
    .addr(progAddr), .target(pTgt), .fregUndef(), .segment(), .page(), .pageOff());

  assign fFlashOff = fetchAddr - FLASH_BASE;
  assign dFlashOff = dEff - FLASH_BASE;
  assign pFlashOff = progAddr - FLASH_BASE;

  // data port reads of flash refused while locked
  assign readLock = readProtEn && (pwState != PW_OPEN);
  assign flashUnlocked = (pwState == PW_OPEN);

  // top of dual-port ram bit window
  // register mode bit access anywhere in dual-port ram
  assign bitOk = dataGpr ? dTgt[T_DUAL_PORT_RAM]
    : ((dEff >= DUAL_PORT_RAM_BIT_BASE && dEff <= DUAL_PORT_RAM_END) || dTgt[T_SREG] || dTgt[T_EREG]);

  assign dErrNow = ((dTgt == '0) && !dFregUndef)
    || (dataBit && !bitOk)
    || (dataGpr && !dTgt[T_DUAL_PORT_RAM])
    || (dTgt[T_FLASH] && (dataWrite || readLock));

  // data reaching program memory uses the link
  assign dProg = dTgt[T_FLASH] || dTgt[T_PROGRAM_SRAM];
  // fetch owns program side when both collide
  assign dataReady = !(dProg && fetchReq);
  assign dataTake = dataReq && dataReady;
  assign progFromData = dataTake && dProg && !dErrNow;

  samd_lane_gen u_lanes (
    .isWord(dataWord), .addr0(dEff[0]), .isBit(dataBit), .bitIdx(bitIdx),
    .wdata(dataWdata), .rword(rword), .be(laneBe), .bitMask(laneMask),
    .laneWdata(laneWdata), .laneRdata(laneRdata));

  // program sram only on program side
  // flash read is one wide cycle
  always_comb
  begin
    flashSel = (fetchReq && fTgt[T_FLASH]) || (progFromData && dTgt[T_FLASH]);
    psramSel = (fetchReq && fTgt[T_PROGRAM_SRAM]) || (progFromData && dTgt[T_PROGRAM_SRAM]);
    flashAddr = fetchReq ? fFlashOff[16:0] : dFlashOff[16:0];
    psramAddr = fetchReq ? fetchAddr[10:0] : dEff[10:0];
    psramWe = progFromData && dTgt[T_PROGRAM_SRAM] && dataWrite;
    psramBe = {6'h00, laneBe} << {dEff[2:1], 1'b0};
    psramWdata = {4{laneWdata}};
  end

  // Word picked from the wide program side read
  assign progWide = dTgt[T_FLASH] ? flashRdata : psramRdata;
  assign progWord = progWide[{dEff[2:1], 4'h0} +: 16];

  // undefined flash register reads give trap code
  assign rword = dFregUndef ? TRAP_CODE : (dProg ? progWord : dmemRdata);

  // data side strobes; data sram only here
  always_comb
  begin
    dmemSel = (dataTake && !dErrNow && !dProg) ? dTgt : '0;
    dmemAddr = dEff;
    dmemWe = dataTake && !dErrNow && !dProg && dataWrite;
    dmemBe = laneBe;
    dmemBitMask = laneMask;
    dmemWdata = laneWdata;
  end

  assign pSect = flashSector(pFlashOff[16:0]);
  assign pProt = (pSect < 3'h4) ? wrProtPair[pSect[1]] : wrProtLarge[2'(pSect - 3'h4)];

  // Answers to fetch, data and programming requests
  always_comb
  begin
    next_fetchAck = fetchReq;
    next_fetchData = fetchData;
    next_fetchErr = fetchReq && !(fTgt[T_FLASH] || fTgt[T_PROGRAM_SRAM]);
    if (fetchReq)
      next_fetchData = fTgt[T_FLASH] ? flashRdata : (fTgt[T_PROGRAM_SRAM] ? psramRdata : '0);
    next_dataAck = dataTake;
    next_dataErr = dataTake && dErrNow;
    next_dataRdata = dataRdata;
    next_dataSeg = dataSeg;
    next_dataPage = dataPage;
    next_dataPageOff = dataPageOff;
    if (dataTake)
    begin
      // Writes and errors read back zero to keep stale data off the bus
      next_dataRdata = (dataWrite || dErrNow) ? 16'h0000 : laneRdata;
      next_dataSeg = dSeg;
      next_dataPage = dPage;
      next_dataPageOff = dOff;
    end
    // grant per sector, block index of 128 bytes
    next_progGrant = progReq && pTgt[T_FLASH] && !pProt && !readLock;
    next_progDenied = progReq && !(pTgt[T_FLASH] && !pProt && !readLock);
    next_progEraseOut = progReq && progErase;
    next_progSector = progReq ? pSect : progSector;
    next_progBlock = progReq ? pFlashOff[BLOCK_LSB +: BLOCK_W] : progBlock;
  end

  always_comb
  begin
    next_pwState = pwState;
    case (pwState)
      PW_LOCKED:
        if (pwdStrobe && pwdWord == PWD_KEY0)
          next_pwState = PW_HALF;
      PW_HALF:
        if (pwdStrobe)
          next_pwState = (pwdWord == PWD_KEY1) ? PW_OPEN : PW_LOCKED;
      PW_OPEN:
        if (relock)
          next_pwState = PW_LOCKED;
      default:
        next_pwState = PW_LOCKED;
    endcase
  end

  // Registered state and answers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pwState <= PW_LOCKED;
      fetchAck <= 1'b0;
      fetchData <= '0;
      fetchErr <= 1'b0;
      dataAck <= 1'b0;
      dataRdata <= 16'h0000;
      dataErr <= 1'b0;
      dataSeg <= 8'h00;
      dataPage <= 2'h0;
      dataPageOff <= 14'h0000;
      progGrant <= 1'b0;
      progDenied <= 1'b0;
      progEraseOut <= 1'b0;
      progSector <= 3'h0;
      progBlock <= '0;
    end
    else
    begin
      pwState <= next_pwState;
      fetchAck <= next_fetchAck;
      fetchData <= next_fetchData;
      fetchErr <= next_fetchErr;
      dataAck <= next_dataAck;
      dataRdata <= next_dataRdata;
      dataErr <= next_dataErr;
      dataSeg <= next_dataSeg;
      dataPage <= next_dataPage;
      dataPageOff <= next_dataPageOff;
      progGrant <= next_progGrant;
      progDenied <= next_progDenied;
      progEraseOut <= next_progEraseOut;
      progSector <= next_progSector;
      progBlock <= next_progBlock;
    end
  end

endmodule : samd_router

//--- test/samd_mem_model.sv
/*
  Far-side memory model for samd_router: flash, program sram and the
  data side targets answer in the cycle their select is high.
  Assumes the router registers every answer itself.
*/
`timescale 1ns/1ps
module samd_mem_model
(
  // Clock
  input wire logic ref_clk,
  // Flash array
  input wire logic flashSel,
  input wire logic [16:0] flashAddr,
  output logic [63:0] flashRdata,
  // Program sram
  input wire logic psramSel,
  input wire logic [10:0] psramAddr,
  output logic [63:0] psramRdata,
  // Data side targets
  input wire logic [7:0] dmemSel,
  input wire logic [23:0] dmemAddr,
  output logic [15:0] dmemRdata
);
  logic tog = 1'b0;

  // Idle lines toggle so that stale data never passes for an answer
  always @(posedge ref_clk) tog <= ~tog;

  assign flashRdata = flashSel ? {4{flashAddr[16:3], 2'b10}} : {64{tog}};
  // Every lane carries the same pattern, so lane picks stay checkable
  assign psramRdata = psramSel ? {4{psramAddr[10:3], 8'hc3}} : {64{tog}};
  assign dmemRdata = |dmemSel ? {dmemAddr[8:1], ~dmemAddr[8:1]} : {16{tog}};
endmodule : samd_mem_model

//--- test/samd_router_sva.sv
/*
  Port checker for samd_router, bound to every instance.
  Assumes one clock domain with an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module samd_router_sva
  import samd_pkg::*;
#(
  parameter logic [23:0] FLASH_BYTES = FLASH_BYTES_DEF,
  parameter logic [23:0] FREG_DEF_BYTES = FREG_DEF_BYTES_DEF
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Fetch port
  input wire logic fetchReq,
  input wire logic [23:0] fetchAddr,
  input wire logic fetchAck,
  input wire logic fetchErr,
  // Data port
  input wire logic dataReq,
  input wire logic [23:0] dataAddr,
  input wire logic dataWrite,
  input wire logic dataWord,
  input wire logic dataBit,
  input wire logic dataGpr,
  input wire logic dataReady,
  input wire logic dataAck,
  input wire logic [15:0] dataRdata,
  input wire logic dataErr,
  input wire logic [7:0] dataSeg,
  input wire logic [1:0] dataPage,
  // Targets
  input wire logic flashSel,
  input wire logic [16:0] flashAddr,
  input wire logic psramSel,
  input wire logic [TGT_W-1:0] dmemSel,
  input wire logic [1:0] dmemBe
);
  logic [23:0] prevAddr;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);

  // Address of the previous edge, for the registered decode
  always_ff @(posedge ref_clk) prevAddr <= dataAddr;

  // Plain data request taken at this edge
  sequence s_take;
    dataReq && dataReady && !dataGpr;
  endsequence
  sequence s_word_read;
    s_take ##0 !dataWrite && !dataBit && dataWord;
  endsequence

  property p_fetch_err;
    fetchReq && fetchAddr < FLASH_BASE |=> fetchAck && fetchErr;
  endproperty
  a_fetch_err: assert property (p_fetch_err) else $error("fetch err missing");
  property p_flash_sel;
    fetchReq && fetchAddr >= FLASH_BASE && fetchAddr < FLASH_BASE + FLASH_BYTES
      |-> flashSel && flashAddr[16:3] == fetchAddr[16:3];
  endproperty
  a_flash_sel: assert property (p_flash_sel) else $error("flash select");
  property p_program_sram_sel;
    fetchReq && fetchAddr inside {[PROGRAM_SRAM_BASE:PROGRAM_SRAM_END]} |-> psramSel ##1 fetchAck && !fetchErr;
  endproperty
  a_program_sram_sel: assert property (p_program_sram_sel) else $error("program_sram fetch");
  property p_onehot;
    $onehot0(dmemSel);
  endproperty
  a_onehot: assert property (p_onehot) else $error("two selects");
  property p_lane;
    s_take ##0 !dataBit && !dataWord && dmemSel != 8'h00 |-> dmemBe == (dataAddr[0] ? 2'b10 : 2'b01);
  endproperty
  a_lane: assert property (p_lane) else $error("byte lane");
  property p_seg;
    s_take |=> dataAck && dataSeg == prevAddr[23:16] && dataPage == prevAddr[15:14];
  endproperty
  a_seg: assert property (p_seg) else $error("segment or page");
  property p_trap;
    s_word_read ##0 dataAddr >= FREG_BASE + FREG_DEF_BYTES |=> !dataErr && dataRdata == TRAP_CODE;
  endproperty
  a_trap: assert property (p_trap) else $error("trap code");
  property p_resv;
    s_take ##0 dataAddr < 24'h008000 |=> dataAck && dataErr;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved data access");
endmodule : samd_router_sva

bind samd_router samd_router_sva #(.FLASH_BYTES(FLASH_BYTES), .FREG_DEF_BYTES(FREG_DEF_BYTES))
  samd_router_sva_i (.*);

//--- test/samd_router_tb_top.sv
/*
  Self-checking bench for samd_router: fetch, data, password and
  programming traffic, answers scored from queues at the falling edge.
  Assumes samd_mem_model stands on the memory side.
*/
`timescale 1ns/1ps
module samd_router_tb_top
  import samd_pkg::*;
;
  localparam logic [15:0] K0 = 16'h9d41;
  localparam logic [15:0] K1 = 16'h62be;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic fetchReq = 1'b0, dataReq = 1'b0, dataWrite = 1'b0, dataWord = 1'b1;
  logic dataBit = 1'b0, dataGpr = 1'b0, readProtEn = 1'b0, pwdStrobe = 1'b0;
  logic relock = 1'b0, progReq = 1'b0, progErase = 1'b0;
  logic [23:0] fetchAddr = 24'h0, dataAddr = 24'h0, progAddr = 24'h0;
  logic [15:0] cpBase = 16'hf600, dataWdata = 16'h0, pwdWord = 16'h0;
  logic [3:0] bitIdx = 4'h0, gprIdx = 4'h0;
  logic [1:0] wrProtPair = 2'h1;
  logic [2:0] wrProtLarge = 3'h2;
  logic fetchAck, fetchErr, dataReady, dataAck, dataErr, flashSel, psramSel, psramWe;
  logic dmemWe, flashUnlocked, progGrant, progDenied, progEraseOut;
  logic [63:0] fetchData, flashRdata, psramRdata, psramWdata;
  logic [15:0] dataRdata, dmemBitMask, dmemWdata, dmemRdata, v;
  logic [23:0] dmemAddr, a;
  logic [16:0] flashAddr;
  logic [13:0] dataPageOff;
  logic [10:0] psramAddr;
  logic [7:0] dataSeg, psramBe, dmemSel;
  logic [2:0] progSector;
  logic [1:0] dataPage, dmemBe;
  logic [BLOCK_W-1:0] progBlock;
  int bad_count = 0;
  int n_compared = 0;
  int cyc = 0;
  logic [79:0] fq[$], dq[$];
  logic [15:0] rnd = 16'hb70b;
  // Map walk: kind 0 target word, 1 error, 2 trap code, 3 program_sram, 4 flash
  logic [26:0] mt [19] = '{{3'd0, 24'h00c000}, {3'd0, 24'h00cffe}, {3'd0, 24'h00f600},
    {3'd0, 24'h00fdfe}, {3'd0, 24'h00fe00}, {3'd0, 24'h00fffe}, {3'd0, 24'h00f000},
    {3'd0, 24'h00f1fe}, {3'd0, 24'h00e000}, {3'd1, 24'h000000}, {3'd1, 24'h007ffe},
    {3'd1, 24'h00d000}, {3'd1, 24'h00f200}, {3'd1, 24'h010000}, {3'd2, 24'hfff100},
    {3'd2, 24'hfffffe}, {3'd3, 24'he00012}, {3'd4, 24'hc00024}, {3'd1, 24'h200000}};
  logic [23:0] fb [4] = '{24'hc00000, 24'he00000, 24'hc20000, 24'h200000};

  samd_router #(.PWD_KEY0(K0), .PWD_KEY1(K1)) samd_router_i (.*);
  samd_mem_model samd_mem_model_i (.*);

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    lfsr = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction : lfsr
  function automatic logic [15:0] ex(input logic [23:0] x);
    ex = {x[8:1], ~x[8:1]};
  endfunction : ex

  task automatic check(input logic [79:0] seen, input logic [79:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Request stays up afterwards, so calls run back to back
  task automatic fop(input logic [23:0] fa, input logic [64:0] fe);
    fetchReq = 1'b1;
    fetchAddr = fa;
    @(posedge ref_clk);
    fq.push_back(80'(fe));
    #2;
  endtask : fop
  task automatic dop(input logic [23:0] da, input logic wr, input logic [16:0] de);
    int n;
    dataReq = 1'b1;
    dataAddr = da;
    dataWrite = wr;
    dataWdata = rnd;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (dataReady !== 1'b1 && n < 20);
    dq.push_back(80'(de));
    #2;
  endtask : dop
  task automatic pw(input logic [15:0] w);
    pwdStrobe = 1'b1;
    pwdWord = w;
    @(posedge ref_clk);
    #2;
  endtask : pw
  task automatic pg(input logic [23:0] pa, input logic g, input logic [12:0] sb);
    logic [79:0] pe;
    progReq = 1'b1;
    progAddr = pa;
    progErase = rnd[0];
    pe = 80'({2'b10, progErase, sb});
    @(posedge ref_clk);
    #2;
    progReq = 1'b0;
    @(negedge ref_clk);
    if (g)
      check(80'({progGrant, progDenied, progEraseOut, progSector, progBlock}), pe);
    else
      check(80'({progGrant, progDenied}), 80'(2'b01));
    rnd = lfsr(rnd);
    @(posedge ref_clk);
    #2;
  endtask : pg
  task automatic done(input string name);
    fetchReq = 1'b0;
    dataReq = 1'b0;
    repeat (3) @(posedge ref_clk);
    #2;
    $display("test %0s done", name);
  endtask : done

  // Clock
  initial forever #25 ref_clk = ~ref_clk;
  // Hang guard
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Scoring mid-cycle, while a one-cycle answer stands
  always @(negedge ref_clk)
  begin
    if (fetchAck === 1'b1)
      check(80'({fetchErr, fetchData}), fq.pop_front());
    if (dataAck === 1'b1)
      check(80'({dataErr, dataRdata}), dq.pop_front());
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    #2;
    rst_b = 1'b1;
    @(posedge ref_clk);
    #2;
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      a = fb[i % 4] + 24'(i % 4 == 1 ? {5'h0, rnd[10:0]} : rnd);
      fop(a, i % 4 == 0 ? {1'b0, {4{a[16:3], 2'b10}}} :
        i % 4 == 1 ? {1'b0, {4{a[10:3], 8'hc3}}} : {1'b1, 64'h0});
    end
    dataReq = 1'b1;
    dataAddr = 24'hc00010;
    fop(24'hc00000, {1'b0, {4{14'h0000, 2'b10}}});
    check(80'(dataReady), 80'(0));
    fop(24'hc00008, {1'b0, {4{14'h0001, 2'b10}}});
    fetchReq = 1'b0;
    dop(24'hc00010, 1'b0, 17'h0000a);
    done("fetch");
    // system map, register areas read only
    foreach (mt[i])
    begin
      a = mt[i][23:0];
      case (mt[i][26:24])
        3'd0: dop(a, 1'b0, {1'b0, ex(a)});
        3'd1: dop(a, 1'b0, 17'h10000);
        3'd2: dop(a, 1'b0, {1'b0, TRAP_CODE});
        3'd3: dop(a, 1'b0, {1'b0, a[10:3], 8'hc3});
        default: dop(a, 1'b0, {1'b0, a[16:3], 2'b10});
      endcase
    end
    dop(24'h00c002, 1'b1, 17'h0);
    check(80'({dmemWe, dmemSel, dmemWdata}), 80'({9'h104, rnd}));
    dop(24'hc00000, 1'b1, 17'h10000);
    dop(24'hfff200, 1'b1, 17'h0);
    dop(24'he00012, 1'b1, 17'h0);
    check(80'({psramWe, psramBe, psramWdata}), 80'({9'h10c, {4{rnd}}}));
    done("map");
    dataBit = 1'b1;
    bitIdx = 4'h5;
    v = ex(24'h00fd10);
    dop(24'h00fd10, 1'b0, {16'h0, v[5]});
    dop(24'h00f600, 1'b0, 17'h10000);
    dataGpr = 1'b1;
    gprIdx = 4'h2;
    bitIdx = 4'h3;
    v = ex(24'h00f604);
    dop(24'h0, 1'b0, {16'h0, v[3]});
    dataBit = 1'b0;
    gprIdx = 4'hf;
    dop(24'h0, 1'b0, {1'b0, ex(24'h00f61e)});
    dataWord = 1'b0;
    gprIdx = 4'h5;
    v = ex(24'h00f605);
    dop(24'h0, 1'b0, {9'h0, v[15:8]});
    cpBase = 16'hc000;
    dop(24'h0, 1'b0, 17'h10000);
    dataGpr = 1'b0;
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      a = 24'h00f600 + 24'(rnd[10:0]);
      dataWord = rnd[11];
      v = ex(a);
      v = rnd[12] ? 16'h0 : dataWord ? v : a[0] ? {8'h0, v[15:8]} : {8'h0, v[7:0]};
      dop(a, rnd[12], {1'b0, v});
    end
    dataWord = 1'b1;
    done("bits");
    readProtEn = 1'b1;
    dop(24'hc00000, 1'b0, 17'h10000);
    dataReq = 1'b0;
    pw(K0);
    pw(K1);
    pwdStrobe = 1'b0;
    @(negedge ref_clk);
    check(80'(flashUnlocked), 80'(1));
    #27;
    dop(24'hc00018, 1'b0, 17'h0000e);
    dataReq = 1'b0;
    relock = 1'b1;
    @(posedge ref_clk);
    #2;
    relock = 1'b0;
    pw(K0);
    pw(16'h1234);
    pwdStrobe = 1'b0;
    @(negedge ref_clk);
    check(80'(flashUnlocked), 80'(0));
    #27;
    pw(K0);
    pw(K1);
    pwdStrobe = 1'b0;
    rst_b = 1'b0;
    repeat (2) @(posedge ref_clk);
    #2;
    rst_b = 1'b1;
    check(80'(flashUnlocked), 80'(0));
    readProtEn = 1'b0;
    done("lock");
    pg(24'hc00000, 1'b0, 13'h0);
    pg(24'hc03f80, 1'b0, 13'h0);
    pg(24'hc04000, 1'b1, {3'd2, 10'h080});
    pg(24'hc07f80, 1'b1, {3'd3, 10'h0ff});
    pg(24'hc08000, 1'b1, {3'd4, 10'h100});
    pg(24'hc10000, 1'b0, 13'h0);
    pg(24'hc18080, 1'b1, {3'd6, 10'h301});
    pg(24'he00000, 1'b0, 13'h0);
    done("prog");
    check(80'(dq.size() + fq.size()), 80'(0));
    conclude();
  end
endmodule : samd_router_tb_top
